// ### rtl/smbus_register_access_slave.sv
// Operation
// - strap latched low maps shared pins to power-down and clock stops
// - all control bytes load defaults at reset
// - host writes control bits that enable individual clock outputs
// - byte write, byte read, block write and block read accepted
// - block bytes go lowest index first, each byte msb first
// - block may stop after any full byte; earlier bytes kept
// - only slave address D2 is answered; bit 0 is not compared, so read address D3 matches too
// - command bit 7 low selects block, high selects single byte
// - command bits 6:0 give byte index; zero for block
// - block write: address, command, count, data bytes, each acked
// - block read: command, repeated start, read address, count then data
// - transactions open with start, seven address bits, write bit
// - byte write: one data byte acked by slave, then stop
// - byte read: repeated start, read address, one byte, host nacks
// - data line is input when receiving; open-drain when acking or sending
`timescale 1ns/1ns
`default_nettype none

module smbus_register_access_slave (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o,
  input wire logic mode_strap_i,
  input wire logic power_down_in_n_i,
  input wire logic cpu_clk_halt_n_i,
  input wire logic pci_clk_halt_n_i,
  output logic pm_pins_active_o,
  output logic power_down_req_o,
  output logic cpu_clk_halt_req_o,
  output logic pci_clk_halt_req_o,
  output logic [smbus_slave_pkg::NUM_BYTES*8-1:0] clk_out_en_o
);

  // ---------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------
  logic rst_s1_q, rst_n;
  logic [5:0] pin_s1_q, pin_s2_q;
  logic scl_d_q, sda_d_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  wire [5:0] pin_raw = {scl_i, serial_data_line_i, mode_strap_i,
    power_down_in_n_i, cpu_clk_halt_n_i, pci_clk_halt_n_i};

  // idle bus levels are high, so the reset value fakes no start
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 6'h3F;
      pin_s2_q <= 6'h3F;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      scl_d_q <= pin_s2_q[5];
      sda_d_q <= pin_s2_q[4];
    end
  end

  wire scl_s = pin_s2_q[5];
  wire sda_s = pin_s2_q[4];
  wire scl_rise = scl_s & ~scl_d_q;
  wire scl_fall = ~scl_s & scl_d_q;
  wire start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // ---------------------------------------------------------------
  // mode strap
  // ---------------------------------------------------------------
  logic [1:0] settle_q;
  logic strap_done_q, mode_q;
  wire pm_en = strap_done_q & (mode_q == smbus_slave_pkg::MODE_PM);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
      mode_q <= 1'b1;
      pm_pins_active_o <= 1'b0;
      power_down_req_o <= 1'b0;
      cpu_clk_halt_req_o <= 1'b0;
      pci_clk_halt_req_o <= 1'b0;
    end else begin
      // synchroniser must settle before the strap is caught once
      if (settle_q != smbus_slave_pkg::SETTLE_CYCLES) begin
        settle_q <= settle_q + smbus_slave_pkg::SETTLE_ONE;
      end else if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        mode_q <= pin_s2_q[3];
      end
      pm_pins_active_o <= pm_en;
      power_down_req_o <= pm_en & ~pin_s2_q[2];
      cpu_clk_halt_req_o <= pm_en & ~pin_s2_q[1];
      pci_clk_halt_req_o <= pm_en & ~pin_s2_q[0];
    end
  end

  // ---------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------
  smbus_slave_pkg::sm_state_t state_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q, tx_q;
  logic got_q, rw_q, block_q, host_nack_q, oe_q, wr_push_q, count_sent_q;
  logic [smbus_slave_pkg::IDX_W-1:0] index_q;
  logic [7:0] regs_q [smbus_slave_pkg::NUM_BYTES];

  wire rx_state = state_q == smbus_slave_pkg::ST_ADDR ||
    state_q == smbus_slave_pkg::ST_CMD ||
    state_q == smbus_slave_pkg::ST_COUNT ||
    state_q == smbus_slave_pkg::ST_WDATA;
  wire addr_match =
    shift_q[7:1] == smbus_slave_pkg::SLAVE_ADDR_W[7:1];
  wire idx_ok = index_q < smbus_slave_pkg::IDX_LIMIT;
  wire [7:0] sel_byte = idx_ok ? regs_q[index_q[2:0]] :
    smbus_slave_pkg::EMPTY_BYTE;
  wire first_read = state_q == smbus_slave_pkg::ST_ADDR_ACK;
  wire [7:0] tx_load_byte = (first_read && block_q) ?
    smbus_slave_pkg::BLOCK_COUNT : sel_byte;
  wire tx_load = scl_fall & ((first_read & rw_q) |
    (state_q == smbus_slave_pkg::ST_TX_ACK & ~host_nack_q));
  wire wr_in_ready;
  wire [smbus_slave_pkg::IDX_W-1:0] index_inc =
    index_q + smbus_slave_pkg::IDX_ONE;

  assign serial_data_line_o = smbus_slave_pkg::SDA_DRIVE_LEVEL;
  assign serial_data_line_oe_o = oe_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= smbus_slave_pkg::ST_IDLE;
      cnt_q <= smbus_slave_pkg::BIT_FIRST;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      got_q <= 1'b0;
      rw_q <= 1'b0;
      block_q <= 1'b0;
      host_nack_q <= 1'b0;
      oe_q <= 1'b0;
      wr_push_q <= 1'b0;
      index_q <= smbus_slave_pkg::IDX_ZERO;
    end else begin
      wr_push_q <= 1'b0;
      if (start_det) begin
        state_q <= smbus_slave_pkg::ST_ADDR;
        cnt_q <= smbus_slave_pkg::BIT_FIRST;
        got_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= smbus_slave_pkg::ST_IDLE;
        got_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        if (rx_state) begin
          shift_q <= {shift_q[6:0], sda_s};
          cnt_q <= cnt_q + smbus_slave_pkg::BIT_ONE;
          got_q <= cnt_q == smbus_slave_pkg::BIT_LAST;
        end
        if (state_q == smbus_slave_pkg::ST_TX_ACK) host_nack_q <= sda_s;
      end else if (scl_fall) begin
        case (state_q)
          smbus_slave_pkg::ST_ADDR: begin
            if (got_q) begin
              got_q <= 1'b0;
              oe_q <= addr_match;
              rw_q <= shift_q[0];
              state_q <= addr_match ? smbus_slave_pkg::ST_ADDR_ACK :
                smbus_slave_pkg::ST_IGNORE;
            end
          end
          smbus_slave_pkg::ST_CMD: begin
            if (got_q) begin
              got_q <= 1'b0;
              oe_q <= 1'b1;
              block_q <= shift_q[smbus_slave_pkg::CMD_BYTE_BIT] ==
                smbus_slave_pkg::CMD_IS_BLOCK;
              index_q <= shift_q[smbus_slave_pkg::CMD_BYTE_BIT] ?
                shift_q[6:0] : smbus_slave_pkg::IDX_ZERO;
              state_q <= smbus_slave_pkg::ST_CMD_ACK;
            end
          end
          smbus_slave_pkg::ST_COUNT: begin
            if (got_q) begin
              got_q <= 1'b0;
              oe_q <= 1'b1;
              state_q <= smbus_slave_pkg::ST_COUNT_ACK;
            end
          end
          smbus_slave_pkg::ST_WDATA: begin
            if (got_q) begin
              got_q <= 1'b0;
              // a full buffer refuses the byte with a nack
              if (wr_in_ready) begin
                oe_q <= 1'b1;
                wr_push_q <= 1'b1;
                index_q <= index_inc;
                state_q <= smbus_slave_pkg::ST_WDATA_ACK;
              end else begin
                state_q <= smbus_slave_pkg::ST_IGNORE;
              end
            end
          end
          smbus_slave_pkg::ST_ADDR_ACK: begin
            cnt_q <= smbus_slave_pkg::BIT_FIRST;
            if (rw_q == smbus_slave_pkg::RW_READ) begin
              tx_q <= tx_load_byte;
              oe_q <= ~tx_load_byte[7];
              state_q <= smbus_slave_pkg::ST_TX;
            end else begin
              oe_q <= 1'b0;
              state_q <= smbus_slave_pkg::ST_CMD;
            end
          end
          smbus_slave_pkg::ST_CMD_ACK: begin
            oe_q <= 1'b0;
            state_q <= block_q ? smbus_slave_pkg::ST_COUNT :
              smbus_slave_pkg::ST_WDATA;
          end
          smbus_slave_pkg::ST_COUNT_ACK, smbus_slave_pkg::ST_WDATA_ACK: begin
            oe_q <= 1'b0;
            state_q <= smbus_slave_pkg::ST_WDATA;
          end
          smbus_slave_pkg::ST_TX: begin
            if (cnt_q == smbus_slave_pkg::BIT_LAST) begin
              oe_q <= 1'b0;
              state_q <= smbus_slave_pkg::ST_TX_ACK;
              // count byte of a block read does not advance the index
              if (!count_sent_q) index_q <= index_inc;
            end else begin
              cnt_q <= cnt_q + smbus_slave_pkg::BIT_ONE;
              tx_q <= {tx_q[6:0], 1'b0};
              oe_q <= ~tx_q[6];
            end
          end
          smbus_slave_pkg::ST_TX_ACK: begin
            cnt_q <= smbus_slave_pkg::BIT_FIRST;
            if (host_nack_q) begin
              state_q <= smbus_slave_pkg::ST_IGNORE;
            end else begin
              tx_q <= tx_load_byte;
              oe_q <= ~tx_load_byte[7];
              state_q <= smbus_slave_pkg::ST_TX;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read index walk: count byte first, then ascending data bytes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count_sent_q <= 1'b0;
    end else if (tx_load) begin
      count_sent_q <= first_read & block_q;
    end
  end

  // ---------------------------------------------------------------
  // write buffer and control bytes
  // ---------------------------------------------------------------
  wire wr_out_valid;
  wire [smbus_slave_pkg::WR_W-1:0] wr_out_data;
  wire wr_fire = wr_out_valid & ~tx_load; // register reads win the slot
  wire [smbus_slave_pkg::IDX_W-1:0] wr_idx = wr_out_data[14:8];
  wire wr_idx_ok = wr_idx < smbus_slave_pkg::IDX_LIMIT;

  smbus_wr_buffer #(
    .WIDTH(smbus_slave_pkg::WR_W)
  ) u_wr_buffer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(wr_push_q),
    .in_ready_o(wr_in_ready),
    .in_data_i({index_q - smbus_slave_pkg::IDX_ONE, shift_q}),
    .out_valid_o(wr_out_valid),
    .out_ready_i(~tx_load),
    .out_data_o(wr_out_data)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < smbus_slave_pkg::NUM_BYTES; i++) begin
        regs_q[i] <= smbus_slave_pkg::REG_DEFAULT;
      end
    end else begin
      if (wr_fire && wr_idx_ok) regs_q[wr_idx[2:0]] <= wr_out_data[7:0];
    end
  end

  genvar g;
  for (g = 0; g < smbus_slave_pkg::NUM_BYTES; g++) begin : g_out
    assign clk_out_en_o[g*8 +: 8] = regs_q[g];
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_rx_released: assert property (@(posedge clk_i)
    disable iff (!rst_n) rx_state |-> !serial_data_line_oe_o)
    else $error("data line driven while receiving");
  a_foreign_nack: assert property (@(posedge clk_i)
    disable iff (!rst_n) state_q == smbus_slave_pkg::ST_IGNORE |-> !oe_q)
    else $error("data line driven in ignored frame");
  a_start_resets: assert property (@(posedge clk_i)
    disable iff (!rst_n) start_det |=> state_q == smbus_slave_pkg::ST_ADDR)
    else $error("start did not restart the frame");
  c_block_read: cover property (@(posedge clk_i)
    tx_load & first_read & block_q);
  c_byte_write: cover property (@(posedge clk_i)
    wr_push_q & ~block_q);
  c_host_nack: cover property (@(posedge clk_i)
    scl_fall & state_q == smbus_slave_pkg::ST_TX_ACK & host_nack_q);

endmodule

`default_nettype wire

// ### rtl/smbus_slave_pkg.sv
package smbus_slave_pkg;

  // ---------------------------------------------------------------
  // addressing and command decode
  // ---------------------------------------------------------------
  localparam logic [7:0] SLAVE_ADDR_W = 8'hD2;
  localparam int CMD_BYTE_BIT = 7;
  localparam logic CMD_IS_BLOCK = 1'b0;
  localparam logic RW_READ = 1'b1;

  // ---------------------------------------------------------------
  // control byte store
  // ---------------------------------------------------------------
  localparam int NUM_BYTES = 8;
  localparam int IDX_W = 7;
  localparam int WR_W = IDX_W + 8;
  localparam logic [IDX_W-1:0] IDX_ZERO = 7'h00;
  localparam logic [IDX_W-1:0] IDX_ONE = 7'h01;
  localparam logic [IDX_W-1:0] IDX_LIMIT = 7'h08;
  localparam logic [7:0] BLOCK_COUNT = 8'h08;
  localparam logic [7:0] REG_DEFAULT = 8'hFF;
  localparam logic [7:0] EMPTY_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // bit timing and strap
  // ---------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [1:0] SETTLE_ONE = 2'h1;
  localparam logic MODE_PM = 1'b0;
  localparam logic SDA_DRIVE_LEVEL = 1'b0;

  // ---------------------------------------------------------------
  // two-entry buffer occupancy
  // ---------------------------------------------------------------
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_COUNT,
    ST_COUNT_ACK, ST_WDATA, ST_WDATA_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
  } sm_state_t;

endpackage

// ### rtl/smbus_wr_buffer.sv
`timescale 1ns/1ns
`default_nettype none

module smbus_wr_buffer #(
  parameter int WIDTH = 15
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [1:0] count_q;
  logic [WIDTH-1:0] slot0_q;
  logic [WIDTH-1:0] slot1_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = count_q != smbus_slave_pkg::BUF_FULL;
  assign out_valid_o = count_q != smbus_slave_pkg::BUF_EMPTY;
  assign out_data_o = slot0_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= smbus_slave_pkg::BUF_EMPTY;
      slot0_q <= '0;
      slot1_q <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_q == smbus_slave_pkg::BUF_EMPTY) slot0_q <= in_data_i;
          else slot1_q <= in_data_i;
          count_q <= count_q + smbus_slave_pkg::BUF_ONE;
        end
        2'b01: begin
          slot0_q <= slot1_q;
          count_q <= count_q - smbus_slave_pkg::BUF_ONE;
        end
        2'b11: begin
          if (count_q == smbus_slave_pkg::BUF_ONE) begin
            slot0_q <= in_data_i;
          end else begin
            slot0_q <= slot1_q;
            slot1_q <= in_data_i;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_push_lands: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) push && count_q == smbus_slave_pkg::BUF_EMPTY
    |=> out_valid_o && out_data_o == $past(in_data_i))
    else $error("pushed word not at the buffer head");
  a_pop_drains: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) pop && !push && count_q == smbus_slave_pkg::BUF_ONE
    |=> !out_valid_o)
    else $error("buffer still valid after last word left");
  a_fill_count: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) push && !pop
    |=> count_q == $past(count_q) + smbus_slave_pkg::BUF_ONE)
    else $error("buffer fill count did not step up");

endmodule

`default_nettype wire

// ### tb/smbus_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// host controller, open-drain data, no clock stretching
// ---------------------------------------------------------------
module smbus_host_model #(
  parameter int HALF = 16
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // data moves only while clock is low, so no false start or stop
  task automatic start_c();
    sda_low_o = 1'b0;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    sda_low_o = 1'b1;
    wt(HALF);
    scl_o = 1'b0;
  endtask

  task automatic stop_c();
    wt(HALF / 2);
    sda_low_o = 1'b1;
    wt(HALF / 2);
    scl_o = 1'b1;
    wt(HALF);
    sda_low_o = 1'b0;
    wt(HALF);
  endtask

  // a one releases the line, so the same cycle also reads
  task automatic bit_c(input logic b, output logic s);
    wt(HALF / 2);
    sda_low_o = ~b;
    wt(HALF / 2);
    scl_o = 1'b1;
    wt(HALF);
    s = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] b, inout int nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], s);
    end
    bit_c(1'b1, s);
    nak += int'(s);
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, b[i]);
    end
    bit_c(last, s);
  endtask

  task automatic wr_tr(input logic [7:0] addr, input logic [7:0] d[$],
                       output int nak);
    nak = 0;
    start_c();
    wr_byte(addr, nak);
    foreach (d[i]) begin
      wr_byte(d[i], nak);
    end
    stop_c();
  endtask

  task automatic rd_tr(input logic [7:0] cmd, input int n,
                       output logic [7:0] r[$], output int nak);
    logic [7:0] b;
    r = {};
    nak = 0;
    start_c();
    wr_byte(smbus_slave_pkg::SLAVE_ADDR_W, nak);
    wr_byte(cmd, nak);
    start_c();
    wr_byte({smbus_slave_pkg::SLAVE_ADDR_W[7:1], smbus_slave_pkg::RW_READ},
            nak);
    for (int i = 0; i < n; i++) begin
      rd_byte(i == n - 1, b);
      r.push_back(b);
    end
    stop_c();
  endtask
endmodule

`default_nettype wire

// ### tb/tb_smbus_register_access_slave.sv
`timescale 1ns/1ns
`default_nettype none

module tb_smbus_register_access_slave;
  logic clk_i, nrst_i, scl, sda_low, sda, strap, pd_n, cpu_n, pci_n;
  logic dut_o, dut_oe, pm, pd_r, cpu_r, pci_r;
  logic [smbus_slave_pkg::NUM_BYTES*8-1:0] en;
  logic [31:0] seed = 32'hE456180F;
  logic [7:0] q[$];
  logic [7:0] r[$];
  logic [7:0] d;
  int model[8];
  int fail_count, total_checks, nak;

  // pull-up: line is low only while someone drives it
  assign sda = ~(sda_low | (dut_oe & ~dut_o));

  smbus_register_access_slave smbus_register_access_slave_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl),
    .serial_data_line_i(sda), .serial_data_line_o(dut_o),
    .serial_data_line_oe_o(dut_oe), .mode_strap_i(strap),
    .power_down_in_n_i(pd_n), .cpu_clk_halt_n_i(cpu_n),
    .pci_clk_halt_n_i(pci_n), .pm_pins_active_o(pm),
    .power_down_req_o(pd_r), .cpu_clk_halt_req_o(cpu_r),
    .pci_clk_halt_req_o(pci_r), .clk_out_en_o(en)
  );

  smbus_host_model smbus_host_model_i (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  // store updates pass a small buffer, so allow a few cycles
  task automatic check_regs();
    repeat (20) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      check(en[8*i +: 8], model[i][7:0]);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (80000) @(posedge clk_i);
    fail_count++;
    $display("[ERR] %0t ns run timed out", $time);
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    strap = 1'b0;
    {pd_n, cpu_n, pci_n} = 3'h7;
    fail_count = 0;
    total_checks = 0;
    for (int i = 0; i < 8; i++) begin
      model[i] = 255;
    end
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    check_regs();
    strap = 1'b1;
    // strap is latched, so a later change must not matter
    for (int k = 0; k < 8; k++) begin
      {pd_n, cpu_n, pci_n} = 3'(rnd());
      repeat (8) @(negedge clk_i);
      check({7'h00, pm}, 8'h01);
      check({5'h00, pd_r, cpu_r, pci_r}, ~{5'h1F, pd_n, cpu_n, pci_n});
    end
    q = {};
    smbus_host_model_i.wr_tr(smbus_slave_pkg::SLAVE_ADDR_W, q, nak);
    check(8'(nak), 8'h00);
    q = {8'h80, 8'h00};
    smbus_host_model_i.wr_tr(8'hD4, q, nak);
    check(8'(nak), 8'h03);
    check_regs();
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      q = {8'h80 | 8'(i), d};
      smbus_host_model_i.wr_tr(smbus_slave_pkg::SLAVE_ADDR_W, q, nak);
      check(8'(nak), 8'h00);
      model[i] = d;
      check_regs();
    end
    // reverse index order catches a read that ignores the offset
    for (int i = 7; i >= 0; i--) begin
      smbus_host_model_i.rd_tr(8'h80 | 8'(i), 1, r, nak);
      check(8'(nak), 8'h00);
      check(r[0], model[i][7:0]);
    end
    for (int n = 8; n >= 3; n -= 5) begin
      q = {8'h00, smbus_slave_pkg::BLOCK_COUNT};
      for (int i = 0; i < n; i++) begin
        d = rnd();
        q.push_back(d);
        model[i] = d;
      end
      smbus_host_model_i.wr_tr(smbus_slave_pkg::SLAVE_ADDR_W, q, nak);
      check(8'(nak), 8'h00);
      check_regs();
    end
    for (int n = 9; n >= 3; n -= 6) begin
      smbus_host_model_i.rd_tr(8'h00, n, r, nak);
      check(8'(nak), 8'h00);
      check(r[0], smbus_slave_pkg::BLOCK_COUNT);
      for (int i = 1; i < n; i++) begin
        check(r[i], model[i-1][7:0]);
      end
    end
    check({7'h00, dut_oe}, 8'h00);
    // second power-up, strap high: shared pins stay unused
    nrst_i = 1'b0;
    strap = 1'b1;
    for (int i = 0; i < 8; i++) begin
      model[i] = 255;
    end
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    check_regs();
    {pd_n, cpu_n, pci_n} = 3'h0;
    repeat (8) @(negedge clk_i);
    check({7'h00, pm}, 8'h00);
    check({5'h00, pd_r, cpu_r, pci_r}, 8'h00);
    complete_run();
  end
endmodule

`default_nettype wire
